// ==== rtl/crp_map.svh ====
// Constants for the clock, reset and pin-state control block
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH
`define CRP_BUS_WIDTH       16
`define CRP_RESET_VECTOR    20'hFFFF0
`define CRP_NMI_TYPE        8'h02
`define CRP_WAKE_DEFAULT    16'h0040
`define CRP_DATA_RESET      16'h0000
`define CRP_SYNC_STAGES     2
`endif

// ==== rtl/crp_pkg.sv ====
// Types for the clock, reset and pin-state control block
package crp_pkg;
   // Bus cycle phase sequencer
   typedef enum logic [2:0] {
      CRP_IDLE,
      CRP_ADDR,
      CRP_DATA,
      CRP_HOLD,
      CRP_WAIT,
      CRP_PDOWN,
      CRP_WAKE
   } crp_phase_t;
endpackage : crp_pkg

// ==== rtl/crp_sync.sv ====
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module crp_sync #(
   parameter int               WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT  = {WIDTH{1'b0}}   // Level each bit wakes up at
) (
   // Clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   // Raw and synchronised levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;   // First stage, read only by second
   logic [WIDTH-1:0] sync_reg;   // Second stage

   ////////////////////////////////////////////////////////////////////////
   // Per-bit chain; reset to the chosen start level of each input
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++)
      begin : g_bit
         always_ff @(posedge i_clock or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               meta_reg[b] <= INIT[b];
               sync_reg[b] <= INIT[b];
            end
            else
            begin
               meta_reg[b] <= i_async[b];
               sync_reg[b] <= meta_reg[b];
            end
         end
      end
   endgenerate

   // Second stage only; the first never leaves this module
   assign o_sync = sync_reg;
endmodule : crp_sync

// ==== rtl/crp_ctrl.sv ====
// Clock, reset and pin-state control for the embedded processor
//
// Behaviour
// - Output clock is half input, 50% duty
// - Reset indicator follows reset request
// - Release realigns clock, fetches from reset vector
// - NMI edge latched, serviced as type two
// - Wait instruction stalls until release input low
// - Address phase then data phase on bus
// - Bus floats while hold acknowledged
// - Bus floats in reset, holds in powerdown
// - Clock outputs keep running in hold/reset/powerdown; divided clock held low in float mode
// - Wake delay after powerdown; timer pin states
// - Crystal drive stays active in float mode
// - Address strobe pulses during address phase
// - Test pin low in reset selects float mode
`timescale 1ns/1ps
`include "crp_map.svh"
module crp_ctrl #(
   parameter int         BUS_WIDTH  = `CRP_BUS_WIDTH,
   parameter logic [15:0] WAKE_COUNT = `CRP_WAKE_DEFAULT
) (
   // Clock and reset
   input  wire logic                 i_clock,
   input  wire logic                 i_rst_n,
   // Asynchronous processor inputs
   input  wire logic                 i_reset_request_in_n,
   input  wire logic                 i_nonmaskable_irq_in,
   input  wire logic                 i_wait_release_in,
   input  wire logic                 i_test_pin_n,
   // Core-side requests
   input  wire logic                 i_bus_req,
   input  wire logic                 i_bus_write,
   input  wire logic [19:0]          i_bus_addr,
   input  wire logic [BUS_WIDTH-1:0] i_bus_wdata,
   input  wire logic                 i_hold_req,
   input  wire logic                 i_wait_instr,
   input  wire logic                 i_pdown_req,
   input  wire logic                 i_wake_req,
   input  wire logic                 i_nmi_ack,
   // Clock outputs
   output logic                      o_divided_clock_out,
   output logic                      o_crystal_drive_out,
   // Reset and core status
   output logic                      o_reset_indicate_out,
   output logic                      o_fetch_start,
   output logic [19:0]               o_fetch_addr,
   output logic                      o_nmi_pending,
   output logic [7:0]                o_nmi_type,
   output logic                      o_stall,
   output logic                      o_hold_ack,
   output logic                      o_pin_float_test_mode,
   // Multiplexed bus
   output logic [BUS_WIDTH-1:0]      o_addr_data_bus,
   output logic                      o_addr_data_bus_oe,
   input  wire logic [BUS_WIDTH-1:0] i_addr_data_bus,
   output logic [BUS_WIDTH-1:0]      o_bus_rdata,
   output logic                      o_address_strobe,
   // Wake delay timer pin
   output logic                      o_wake_delay_timer_pin,
   output logic                      o_wake_delay_timer_pin_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronised inputs
   logic [1:0] sync_w;              // {nmi, reset request}
   logic       rst_req_s;           // Synchronous active-low reset request
   logic       nmi_s;               // Synchronous NMI level

   // Both bits wake up low: the request reads as active, so the block
   // starts in reset, and the interrupt reads idle, so no false edge
   crp_sync #(.WIDTH(2), .INIT(2'h0)) u_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async ({i_nonmaskable_irq_in, i_reset_request_in_n}),
      .o_sync  (sync_w)
   );
   assign rst_req_s = sync_w[0];
   assign nmi_s     = sync_w[1];

   ////////////////////////////////////////////////////////////////////////
   // State and registers
   crp_pkg::crp_phase_t      phase_reg, phase_next;
   logic                     in_reset_reg;   // Reset state held
   logic                     float_mode_reg; // Float test mode latched
   logic                     stall_reg;      // Wait phase shown to the core
   logic                     hold_ack_reg;   // Hold phase shown to the bus master
   logic                     nmi_prev_reg;   // Edge detect history
   logic                     nmi_pend_reg;   // Latched NMI
   logic [BUS_WIDTH-1:0]     bus_out_reg;    // Driven bus value
   logic                     bus_oe_reg;
   logic                     ale_reg;
   logic [15:0]              wake_cnt_reg;
   logic                     fetch_reg;
   logic [BUS_WIDTH-1:0]     rdata_reg;
   logic                     clk_out_reg;    // Half-rate clock pin copy
   logic                     osc_reg;        // Crystal drive, never gated
   logic                     timer_oe_reg;   // Wake timer pin enable
   logic                     timer_pin_reg;  // Wake timer pin level

   // Decodes
   wire reset_now   = !rst_req_s;
   wire release_now = in_reset_reg && rst_req_s;
   wire nmi_rise    = nmi_s && !nmi_prev_reg;
   wire drive_ok    = !float_mode_reg;
   wire [BUS_WIDTH-1:0] addr_low = i_bus_addr[BUS_WIDTH-1:0];
   wire enter_wait  = phase_next == crp_pkg::CRP_WAIT;   // Stall from the same edge
   wire enter_hold  = phase_next == crp_pkg::CRP_HOLD;   // Ack with the bus release

   ////////////////////////////////////////////////////////////////////////
   // Half-rate clock: one toggle each input-clock falling edge, so the
   // level is held a full input period high and low. It keeps running in
   // reset, hold and powerdown; only a reset-request release restarts its
   // phase, so the first fetch after reset sees a known clock alignment.
   logic div_reg;        // Free-running half-rate phase
   logic req_seen_reg;   // Request level seen on the last falling edge
   wire  realign  = rst_req_s && !req_seen_reg;    // Release just seen
   wire  div_next = realign ? 1'b0 : ~div_reg;
   always_ff @(negedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         div_reg      <= 1'b0;
         req_seen_reg <= 1'b0;
         clk_out_reg  <= 1'b0;
      end
      else
      begin
         req_seen_reg <= rst_req_s;
         div_reg      <= div_next;
         clk_out_reg  <= div_next && drive_ok;     // Low while pins float
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer
   always_comb
   begin
      phase_next = phase_reg;
      unique case (phase_reg)
         crp_pkg::CRP_IDLE:
            if (i_hold_req)
               phase_next = crp_pkg::CRP_HOLD;
            else if (i_pdown_req)
               phase_next = crp_pkg::CRP_PDOWN;
            else if (i_wait_instr)
               phase_next = crp_pkg::CRP_WAIT;
            else if (i_bus_req)
               phase_next = crp_pkg::CRP_ADDR;
         crp_pkg::CRP_ADDR:
            phase_next = crp_pkg::CRP_DATA;
         crp_pkg::CRP_DATA:
            phase_next = crp_pkg::CRP_IDLE;
         crp_pkg::CRP_HOLD:
            if (!i_hold_req)
               phase_next = crp_pkg::CRP_IDLE;
         crp_pkg::CRP_WAIT:
            if (!i_wait_release_in)
               phase_next = crp_pkg::CRP_IDLE;
         crp_pkg::CRP_PDOWN:
            if (i_wake_req)
               phase_next = crp_pkg::CRP_WAKE;
         crp_pkg::CRP_WAKE:
            if (wake_cnt_reg == 16'h0000)
               phase_next = crp_pkg::CRP_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase, reset flag and float-mode latch
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_reg      <= crp_pkg::CRP_IDLE;
         in_reset_reg   <= 1'b1;
         float_mode_reg <= 1'b0;
         stall_reg      <= 1'b0;
         hold_ack_reg   <= 1'b0;
      end
      else if (reset_now)
      begin
         phase_reg      <= crp_pkg::CRP_IDLE;
         in_reset_reg   <= 1'b1;
         float_mode_reg <= !i_test_pin_n;
         stall_reg      <= 1'b0;
         hold_ack_reg   <= 1'b0;
      end
      else
      begin
         phase_reg      <= phase_next;
         in_reset_reg   <= 1'b0;
         stall_reg      <= enter_wait;
         hold_ack_reg   <= enter_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // NMI latch; new edge wins over acknowledge
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         nmi_prev_reg <= 1'b0;
         nmi_pend_reg <= 1'b0;
      end
      else
      begin
         nmi_prev_reg <= nmi_s;
         if (reset_now)
            nmi_pend_reg <= 1'b0;
         else if (nmi_rise)
            nmi_pend_reg <= 1'b1;
         else if (i_nmi_ack)
            nmi_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake delay counter, reloaded every cycle in powerdown
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         wake_cnt_reg <= 16'h0000;
      else if (phase_reg == crp_pkg::CRP_PDOWN)
         wake_cnt_reg <= WAKE_COUNT;
      else if (phase_reg == crp_pkg::CRP_WAKE && wake_cnt_reg != 16'h0000)
         wake_cnt_reg <= wake_cnt_reg - 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus pins: float in reset/hold/test mode, hold value in powerdown
   wire in_pdown = phase_reg == crp_pkg::CRP_PDOWN || phase_reg == crp_pkg::CRP_WAKE;
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bus_out_reg <= `CRP_DATA_RESET;
         bus_oe_reg  <= 1'b0;
         ale_reg     <= 1'b0;
         rdata_reg   <= `CRP_DATA_RESET;
      end
      else if (reset_now || float_mode_reg)
      begin
         bus_oe_reg <= 1'b0;
         ale_reg    <= 1'b0;
      end
      else if (phase_next == crp_pkg::CRP_HOLD)
      begin
         bus_oe_reg <= 1'b0;
         ale_reg    <= 1'b0;
      end
      else if (phase_next == crp_pkg::CRP_ADDR)
      begin
         bus_out_reg <= addr_low;
         bus_oe_reg  <= 1'b1;
         ale_reg     <= 1'b1;
      end
      else if (phase_next == crp_pkg::CRP_DATA)
      begin
         bus_out_reg <= i_bus_wdata;
         bus_oe_reg  <= i_bus_write;
         ale_reg     <= 1'b0;
      end
      else if (!in_pdown)
      begin
         if (phase_reg == crp_pkg::CRP_DATA && !i_bus_write)
            rdata_reg <= i_addr_data_bus;
         ale_reg <= 1'b0;
      end
      // Powerdown: all bus state simply held
   end

   ////////////////////////////////////////////////////////////////////////
   // Crystal drive, wake timer pin and fetch pulse
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         osc_reg       <= 1'b0;
         timer_oe_reg  <= 1'b0;
         timer_pin_reg <= 1'b0;
         fetch_reg     <= 1'b0;
      end
      else
      begin
         osc_reg       <= ~osc_reg;
         timer_oe_reg  <= !reset_now && drive_ok && in_pdown;
         timer_pin_reg <= in_pdown;              // High whenever enabled
         fetch_reg     <= release_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_divided_clock_out       = clk_out_reg;
   assign o_crystal_drive_out       = osc_reg;
   assign o_reset_indicate_out      = in_reset_reg;
   assign o_fetch_start             = fetch_reg;
   assign o_fetch_addr              = `CRP_RESET_VECTOR;
   assign o_nmi_pending             = nmi_pend_reg;
   assign o_nmi_type                = `CRP_NMI_TYPE;
   assign o_stall                   = stall_reg;
   assign o_hold_ack                = hold_ack_reg;
   assign o_pin_float_test_mode     = float_mode_reg;
   assign o_addr_data_bus           = bus_out_reg;
   assign o_addr_data_bus_oe        = bus_oe_reg;
   assign o_bus_rdata               = rdata_reg;
   assign o_address_strobe          = ale_reg;
   assign o_wake_delay_timer_pin    = timer_pin_reg;
   assign o_wake_delay_timer_pin_oe = timer_oe_reg;
endmodule : crp_ctrl

// ==== testbench/crp_ctrl_monitor.sv ====
// Concurrent checks on the pin-state control block
`timescale 1ns/1ps
module crp_ctrl_monitor #(
   parameter int          BUS_WIDTH  = 16,
   parameter logic [15:0] WAKE_COUNT = 16'h0004
) (
   // Clock and reset
   input wire logic                 i_clock,
   input wire logic                 i_rst_n,
   // Watched inputs
   input wire logic                 i_reset_request_in_n,
   input wire logic                 i_bus_write,
   input wire logic [19:0]          i_bus_addr,
   input wire logic [BUS_WIDTH-1:0] i_bus_wdata,
   // Watched outputs
   input wire logic                 o_crystal_drive_out,
   input wire logic                 o_divided_clock_out,
   input wire logic                 o_reset_indicate_out,
   input wire logic                 o_hold_ack,
   input wire logic                 o_pin_float_test_mode,
   input wire logic [BUS_WIDTH-1:0] o_addr_data_bus,
   input wire logic                 o_addr_data_bus_oe,
   input wire logic                 o_address_strobe,
   input wire logic                 o_wake_delay_timer_pin,
   input wire logic                 o_wake_delay_timer_pin_oe
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Address phase opens; request held long enough to pass the synchroniser
   sequence s_addr; o_address_strobe; endsequence
   sequence s_req_low; !i_reset_request_in_n [*4]; endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_XTAL_RUNS: assert property ($past(i_rst_n) |->
      o_crystal_drive_out != $past(o_crystal_drive_out)) else $error("crystal stalled");
   AST_DIV_TOGGLE: assert property ($past(i_rst_n) && !o_reset_indicate_out &&
      !$past(o_reset_indicate_out) && !o_pin_float_test_mode && !$past(o_pin_float_test_mode)
      |-> o_divided_clock_out != $past(o_divided_clock_out)) else $error("clock out stuck");
   AST_STROBE_ONE: assert property (s_addr |=> !o_address_strobe)
      else $error("strobe too long");
   AST_ADDR_PHASE: assert property (s_addr |-> o_addr_data_bus_oe &&
      o_addr_data_bus == $past(i_bus_addr[BUS_WIDTH-1:0])) else $error("bad address phase");
   AST_DATA_PHASE: assert property (s_addr |=> o_addr_data_bus_oe == $past(i_bus_write)
      && (!o_addr_data_bus_oe || o_addr_data_bus == $past(i_bus_wdata)))
      else $error("bad data phase");
   AST_RESET_FLOAT: assert property (o_reset_indicate_out |->
      !o_addr_data_bus_oe && !o_wake_delay_timer_pin_oe) else $error("pin driven in reset");
   AST_RESET_FOLLOW: assert property (s_req_low |-> o_reset_indicate_out)
      else $error("reset indicator low");
   AST_HOLD_FLOAT: assert property (o_hold_ack |-> !o_addr_data_bus_oe)
      else $error("bus driven in hold");
   AST_TEST_FLOAT: assert property (o_pin_float_test_mode |-> !o_addr_data_bus_oe &&
      !o_address_strobe && !o_divided_clock_out && !o_wake_delay_timer_pin_oe)
      else $error("pin driven in float mode");
   AST_TIMER_HIGH: assert property (o_wake_delay_timer_pin_oe |-> o_wake_delay_timer_pin)
      else $error("timer pin not high");
endmodule : crp_ctrl_monitor
bind crp_ctrl crp_ctrl_monitor #(.BUS_WIDTH(BUS_WIDTH), .WAKE_COUNT(WAKE_COUNT)) u_mon (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_request_in_n(i_reset_request_in_n),
   .i_bus_write(i_bus_write), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
   .o_crystal_drive_out(o_crystal_drive_out), .o_divided_clock_out(o_divided_clock_out),
   .o_reset_indicate_out(o_reset_indicate_out), .o_hold_ack(o_hold_ack),
   .o_pin_float_test_mode(o_pin_float_test_mode), .o_addr_data_bus(o_addr_data_bus),
   .o_addr_data_bus_oe(o_addr_data_bus_oe), .o_address_strobe(o_address_strobe),
   .o_wake_delay_timer_pin(o_wake_delay_timer_pin),
   .o_wake_delay_timer_pin_oe(o_wake_delay_timer_pin_oe));

// ==== testbench/crp_bus_dev.sv ====
// Bus device model answering reads on the multiplexed bus
`timescale 1ns/1ps
module crp_bus_dev (
   input  wire logic        i_clock,
   input  wire logic        i_strobe,
   input  wire logic [15:0] i_bus,
   output logic      [15:0] o_drive
);
   // Inverted address after a strobe, else a pattern that moves every cycle
   initial o_drive = 16'h1234;
   always @(posedge i_clock)
      o_drive <= i_strobe ? ~i_bus : (o_drive ^ 16'h5A5A);
endmodule : crp_bus_dev

// ==== testbench/tb.sv ====
// Self-checking bench for the pin-state control block
`timescale 1ns/1ps
module tb;
   typedef struct packed { logic w; logic [19:0] a; logic [15:0] d; } crp_row_t;
   // Stimulus
   logic        i_clock = 1'b0, i_rst_n = 1'b0, rq_n = 1'b0, nmi = 1'b0, wrel = 1'b1;
   logic        test_n = 1'b1, req = 1'b0, wr = 1'b0, hold = 1'b0, wi = 1'b0;
   logic        pd = 1'b0, wk = 1'b0, ack = 1'b0, x;
   logic [19:0] addr = 20'h00000, faddr;
   logic [15:0] wd = 16'h0000, bus_o, rdata, dev_drv;
   // Design outputs
   logic        dclk, xtal, rind, fst, npend, stall, hack, ftm, oe, stb, pdt, pdt_oe;
   logic [7:0]  ntype;
   wire  [15:0] bus_w = oe ? bus_o : dev_drv;
   wire  [4:0]  mon = {pdt_oe, hack, stall, npend, fst};
   int          n_fail = 0, samples_checked = 0, n;
   crp_row_t    rows [4] = '{{1'b1, 20'h01234, 16'hABCD}, {1'b0, 20'hFFFF0, 16'h0000},
                             {1'b1, 20'h00000, 16'hFFFF}, {1'b0, 20'h5A5A5, 16'h0000}};
   always #2 i_clock = ~i_clock;
   ////////////////////////////////////////////////////////////////////////////
   crp_ctrl #(.WAKE_COUNT(16'h0004)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_reset_request_in_n(rq_n), .i_nonmaskable_irq_in(nmi), .i_wait_release_in(wrel),
      .i_test_pin_n(test_n), .i_bus_req(req), .i_bus_write(wr), .i_bus_addr(addr),
      .i_bus_wdata(wd), .i_hold_req(hold), .i_wait_instr(wi), .i_pdown_req(pd),
      .i_wake_req(wk), .i_nmi_ack(ack), .o_divided_clock_out(dclk),
      .o_crystal_drive_out(xtal), .o_reset_indicate_out(rind), .o_fetch_start(fst),
      .o_fetch_addr(faddr), .o_nmi_pending(npend), .o_nmi_type(ntype), .o_stall(stall),
      .o_hold_ack(hack), .o_pin_float_test_mode(ftm), .o_addr_data_bus(bus_o),
      .o_addr_data_bus_oe(oe), .i_addr_data_bus(bus_w), .o_bus_rdata(rdata),
      .o_address_strobe(stb), .o_wake_delay_timer_pin(pdt), .o_wake_delay_timer_pin_oe(pdt_oe));
   crp_bus_dev u_dev (.i_clock(i_clock), .i_strobe(stb), .i_bus(bus_o), .o_drive(dev_drv));
   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Bounded wait on one status output; n returns the cycles taken
   task waitsig(input int s, input logic v, output int c);
      for (c = 0; c < 40 && mon[s] !== v; c++)
      begin
         @(posedge i_clock);
         #1;
      end
      if (mon[s] !== v)
      begin
         n_fail++;
         $display("[FAIL] status_bit_%0d expected %b seen %b", s, v, mon[s]);
         summarize();
      end
   endtask : waitsig
   // One bus transfer, request held until the strobe answers
   task xfer(input crp_row_t r);
      logic [15:0] e;
      e = ~r.a[15:0];
      @(posedge i_clock);
      {req, wr, addr, wd} <= {1'b1, r};
      for (n = 0; n < 8 && stb !== 1'b1; n++)
      begin
         @(posedge i_clock);
         #1;
      end
      if (stb !== 1'b1)
      begin
         n_fail++;
         $display("[FAIL] strobe expected 1 seen %b", stb);
         summarize();
      end
      chk("addr_phase", r.a[15:0], bus_o);
      @(posedge i_clock);
      req <= 1'b0;
      #1;
      chk("strobe_end", 1'b0, stb);
      chk("data_oe", r.w, oe);
      if (r.w) chk("wdata", r.d, bus_o);
      @(posedge i_clock);
      #1;
      if (!r.w) chk("rdata", e, rdata);
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      #1;
      chk("reset_ind", 1'b1, rind);
      chk("bus_oe", 1'b0, oe);
      @(posedge i_clock);
      rq_n <= 1'b1;
      waitsig(0, 1'b1, n);
      chk("fetch_addr", 20'hFFFF0, faddr);
      repeat (3) @(posedge i_clock);
      foreach (rows[i]) xfer(rows[i]);
      @(posedge i_clock);
      nmi <= 1'b1;
      waitsig(1, 1'b1, n);
      chk("nmi_type", 8'h02, ntype);
      @(posedge i_clock);
      {ack, nmi} <= 2'b10;
      @(posedge i_clock);
      ack <= 1'b0;
      #1;
      chk("nmi_clear", 1'b0, npend);
      // New edge and acknowledge in one cycle: the edge must win
      @(posedge i_clock);
      nmi <= 1'b1;
      repeat (2) @(posedge i_clock);
      ack <= 1'b1;
      @(posedge i_clock);
      ack <= 1'b0;
      #1;
      chk("nmi_edge_wins", 1'b1, npend);
      @(posedge i_clock);
      wi <= 1'b1;
      waitsig(2, 1'b1, n);
      @(posedge i_clock);
      wi <= 1'b0;
      repeat (2) @(posedge i_clock);
      wrel <= 1'b0;
      #1;
      chk("stall_held", 1'b1, stall);
      waitsig(2, 1'b0, n);
      @(posedge i_clock);
      {wrel, hold, req, wr} <= 4'b1111;
      waitsig(3, 1'b1, n);
      repeat (3) @(posedge i_clock);
      {hold, req} <= 2'b00;
      #1;
      chk("hold_oe", 1'b0, oe);
      @(posedge i_clock);
      pd <= 1'b1;
      waitsig(4, 1'b1, n);
      chk("timer_pin", 1'b1, pdt);
      x = dclk;
      @(posedge i_clock);
      {pd, wk} <= 2'b01;
      #1;
      chk("clock_out", !x, dclk);
      waitsig(4, 1'b0, n);
      chk("wake_delay", 1'b1, n >= 4);
      @(posedge i_clock);
      {wk, rq_n, test_n} <= 3'b000;
      repeat (5) @(posedge i_clock);
      rq_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      #1;
      x = xtal;
      @(posedge i_clock);
      test_n <= 1'b1;
      #1;
      chk("float_mode", 1'b1, ftm);
      chk("float_oe", 1'b0, oe);
      chk("xtal_runs", !x, xtal);
      summarize();
   end
endmodule : tb
